// [shared/pmld_pkg.sv]
// Package for the lane MAC, training and deskew block.
// Assumes one 100 MHz clock and eight lanes of one symbol per clock.
package pmld_pkg;
  // ==========================================================
  // Sizes
  localparam int LANES = 8;
  localparam int SYM_W = 10;
  localparam int FIFO_DEPTH = 8;
  // ==========================================================
  // Symbol codes
  localparam logic [7:0] K_COM = 8'hbc;
  localparam logic [7:0] K_SKP = 8'h1c;
  localparam logic [7:0] K_FTS = 8'h3c;
  localparam logic [7:0] K_PAD = 8'hf7;
  localparam logic [7:0] K_IDL = 8'h7c;
  localparam logic [7:0] D_TS1 = 8'h4a;
  localparam logic [7:0] D_TS2 = 8'h45;
  localparam logic [7:0] D_ZERO = 8'h00;
  localparam logic [7:0] LINK_NUM = 8'h00;
  localparam logic [7:0] NFTS_VAL = 8'h20;
  localparam logic [7:0] RATE_VAL = 8'h02;
  // ==========================================================
  // Ordered set layout
  localparam logic [3:0] POS_LINK = 4'h1;
  localparam logic [3:0] POS_LANE = 4'h2;
  localparam logic [3:0] POS_NFTS = 4'h3;
  localparam logic [3:0] POS_RATE = 4'h4;
  localparam logic [3:0] POS_ID = 4'h6;
  localparam logic [3:0] TS_LAST = 4'hf;
  localparam logic [3:0] SKP_LAST = 4'h3;
  localparam logic [3:0] TS_MIN = 4'h8;
  localparam logic [15:0] LFSR_SEED = 16'hffff;
  localparam logic [2:0] RXDET_YES = 3'h3;
  // ==========================================================
  // Timing
  localparam int CLK_NS = 10;
  localparam int QUIET_NS = 1000;
  localparam logic [10:0] QUIET_CYC = 11'(QUIET_NS / CLK_NS);
  localparam int SKP_NS = 11800;
  localparam logic [10:0] SKP_CYC = 11'(SKP_NS / CLK_NS);
  localparam logic [2:0] DSK_WAIT_CYC = 3'h7;
  // ==========================================================
  // States
  typedef enum logic [2:0] {
    LT_QUIET = 3'b000, LT_DETECT = 3'b001, LT_POLL = 3'b010, LT_CFG = 3'b011, LT_L0 = 3'b100
  } pmld_lt_t;
  typedef enum logic [1:0] {DSK_OFF = 2'b00, DSK_HUNT = 2'b01, DSK_WAIT = 2'b10, DSK_LOCK = 2'b11} pmld_dsk_t;
  typedef enum logic [1:0] {OS_TS1 = 2'b00, OS_TS2 = 2'b01, OS_SKP = 2'b10} pmld_os_t;
  // Control symbol match, used for every lane
  function automatic logic pmld_kmatch(input logic k, input logic [7:0] d, input logic [7:0] c);
    return k && (d == c);
  endfunction : pmld_kmatch
endpackage : pmld_pkg

// [rtl/pmld_fifo.sv]
// Small synchronous FIFO with valid/ready on both sides and a flush.
// Depth must be a power of two so the pointers wrap by themselves.
`timescale 1ns/100ps
module pmld_fifo #(
  parameter int W = 10,
  parameter int D = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  // ==========================================================
  // Flags
  assign in_ready = cnt_q != (AW+1)'(D);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rp_q];
  // Storage, no reset needed on data
  always_ff @(posedge clk_sys) begin
    if (push) mem_q[wp_q] <= in_data;
  end
  // Pointers; flush beats a same-cycle push
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_q + AW'(push);
      rp_q <= rp_q + AW'(pop);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : pmld_fifo

// [rtl/pmld_scram.sv]
// Lane scrambler LFSR giving eight key bits per symbol.
// Reseeded by COM, held on SKP by the caller through adv.
`timescale 1ns/100ps
module pmld_scram (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic seed,
  input wire logic adv,
  output logic [7:0] key
);
  logic [15:0] lfsr_q;
  logic [23:0] step_w;
  // ==========================================================
  // Eight serial steps of x^16+x^5+x^4+x^3+1
  function automatic logic [23:0] pmld_step(input logic [15:0] s);
    logic [15:0] l;
    logic [7:0] k;
    l = s;
    k = '0;
    for (int b = 0; b < 8; b++) begin
      k[b] = l[15];
      l = {l[14:0], l[15]} ^ {10'h000, l[15], l[15], l[15], 3'h0};
    end
    return {l, k};
  endfunction : pmld_step
  assign step_w = pmld_step(lfsr_q);
  assign key = step_w[7:0];
  // State update
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) lfsr_q <= pmld_pkg::LFSR_SEED;
    else if (seed) lfsr_q <= pmld_pkg::LFSR_SEED;
    else if (adv) lfsr_q <= step_w[23:8];
  end
endmodule : pmld_scram

// [rtl/pmld_top.sv]
// Lane MAC, link training, ordered set / skip generation and deskew.
// Assumes PIPE signals synchronous to clk_sys, one symbol per lane per clock.
// Contract
// - One eight-word FIFO per lane holds received symbols during alignment.
// - Each stored symbol is ten bits: data byte, disparity, control flag.
// - FTS, COM and SKP symbols are dropped, never passed upward.
// - Received PAD and IDL become data symbol D0.0.
// - Read only when all eight lane FIFOs hold an entry.
// - After enable, a lane FIFO starts writing after its first COM.
// - Lanes lacking COM within seven cycles: flush all and resynchronise.
// - Aligned lanes form a 64-bit word for the link layer.
// - Receive lanes report type and count of TS1/TS2 received.
// - Transmit lanes pick link layer data or ordered set generator output.
// - Transmit lanes insert lane number; disabled lanes send PAD.
// - Training tracks sent and received training sets per lane.
// - Training drives link-wide and per-lane controls to emit sets.
// - Training enables deskew and reports physical status upward.
// - Same set on all lanes, PAD in link/lane fields where required.
// - Receiver detect: assert PIPE detect, wait for PHY status result.
// - SKP sets go out each interval, never inside a packet.
// - Scramble transmit data, descramble receive data.
`timescale 1ns/100ps
module pmld_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [63:0] pipe_rx_data,
  input wire logic [7:0] pipe_rx_k,
  input wire logic [7:0] pipe_rx_disp,
  input wire logic pipe_phy_status,
  input wire logic [2:0] pipe_rx_status,
  output logic [63:0] pipe_tx_data,
  output logic [7:0] pipe_tx_k,
  output logic pipe_tx_detect_rx,
  output logic pipe_tx_elec_idle,
  input wire logic [63:0] dll_tx_data,
  input wire logic [7:0] dll_tx_k,
  input wire logic dll_tx_valid,
  input wire logic dll_tx_pkt,
  output logic dll_tx_ready,
  output logic [63:0] dll_rx_data,
  output logic dll_rx_valid,
  input wire logic dll_rx_ready,
  input wire logic [7:0] lane_disable,
  output logic link_up,
  output logic [2:0] ltssm_state,
  output logic deskew_locked,
  output logic deskew_overflow,
  output logic [31:0] rx_ts_cnt,
  output logic [7:0] rx_ts2_flag,
  output logic [31:0] tx_ts_cnt
);
  pmld_pkg::pmld_lt_t lt_q, lt_d;
  pmld_pkg::pmld_dsk_t dsk_q, dsk_d;
  pmld_pkg::pmld_os_t os_kind_q, os_kind_d;
  logic [10:0] tmr_q, skp_tmr_q;
  logic [3:0] os_cnt_q;
  logic [2:0] dsk_cnt_q;
  logic [7:0] sync_q, sync_d;
  logic skp_pend_q, skp_pend_d, os_run_q, os_run_d, rdy_q, rdy_d;
  logic det_q, eidle_q, up_q, lock_q, ovf_q, rxv_q;
  logic [63:0] txd_q, rxw_q, tx_word_w, rd_word_w;
  logic [7:0] txk_q, tx_kw_w, tx_key;
  logic [7:0] com_w, push_w, fill_rdy_w, fo_valid_w, rx_ok_w, tx_ok_w;
  logic [pmld_pkg::SYM_W-1:0] fo_data_w [pmld_pkg::LANES];

  // ==========================================================
  // Shared controls
  wire dsk_en = lt_q == pmld_pkg::LT_L0;
  wire in_cfg = lt_q == pmld_pkg::LT_CFG;
  wire training = (lt_q == pmld_pkg::LT_POLL) | in_cfg;
  wire hunting = (dsk_q == pmld_pkg::DSK_HUNT) | (dsk_q == pmld_pkg::DSK_WAIT);
  wire all_sync = &sync_d;
  wire ovf = |(push_w & ~fill_rdy_w);
  wire timeout = (dsk_q == pmld_pkg::DSK_WAIT) & ~all_sync
    & (dsk_cnt_q == pmld_pkg::DSK_WAIT_CYC - 3'h1);
  wire dsk_flush = ((dsk_q != pmld_pkg::DSK_OFF) & ~dsk_en) | ovf | timeout;
  wire rd_w = (dsk_q == pmld_pkg::DSK_LOCK) & (&fo_valid_w) & (~rxv_q | dll_rx_ready);
  wire tmr_done = tmr_q == pmld_pkg::QUIET_CYC - 11'h001;
  wire skp_hit = skp_tmr_q == pmld_pkg::SKP_CYC - 11'h001;
  wire acc = dll_tx_valid & rdy_q;
  assign sync_d = sync_q | (com_w & {8{hunting}});

  // ==========================================================
  // Ordered set generator
  wire os_is_skp = os_kind_q == pmld_pkg::OS_SKP;
  wire os_last = os_cnt_q == (os_is_skp ? pmld_pkg::SKP_LAST : pmld_pkg::TS_LAST);
  wire os_fld = (os_cnt_q == pmld_pkg::POS_LINK) | (os_cnt_q == pmld_pkg::POS_LANE);
  // SKP waits until the link layer is idle and already stalled
  wire skp_l0 = dsk_en & skp_pend_q & ~rdy_q & ~dll_tx_pkt & ~os_run_q;
  wire os_next = (training & (~os_run_q | os_last)) | skp_l0;
  wire os_k = (os_cnt_q == 4'h0) | os_is_skp | os_fld;
  wire [7:0] os_d = (os_cnt_q == 4'h0) ? pmld_pkg::K_COM
    : os_is_skp ? pmld_pkg::K_SKP
    : os_fld ? pmld_pkg::K_PAD
    : (os_cnt_q == pmld_pkg::POS_NFTS) ? pmld_pkg::NFTS_VAL
    : (os_cnt_q == pmld_pkg::POS_RATE) ? pmld_pkg::RATE_VAL
    : (os_cnt_q < pmld_pkg::POS_ID) ? pmld_pkg::D_ZERO
    : (os_kind_q == pmld_pkg::OS_TS2) ? pmld_pkg::D_TS2 : pmld_pkg::D_TS1;
  // Lane fields are filled per lane only once the link is configuring
  wire lane_fld = in_cfg & os_fld & ~os_is_skp;
  assign os_kind_d = skp_pend_q ? pmld_pkg::OS_SKP
    : in_cfg ? pmld_pkg::OS_TS2 : pmld_pkg::OS_TS1;
  assign os_run_d = os_next | (os_run_q & ~os_last);
  assign skp_pend_d = skp_hit | (skp_pend_q & ~os_next);
  assign rdy_d = (lt_d == pmld_pkg::LT_L0) & ~(skp_pend_d & ~dll_tx_pkt) & ~os_run_d;

  // Transmit scrambler, one key shared by all lanes
  pmld_scram u_tx_scram (
    .clk_sys(clk_sys),
    .rst(rst),
    .seed(os_run_q & (os_cnt_q == 4'h0)),
    .adv(~(os_run_q & os_is_skp)),
    .key(tx_key)
  );

  // ==========================================================
  // Per-lane transmit and receive
  for (genvar i = 0; i < pmld_pkg::LANES; i++) begin : g_lane
    logic [7:0] d_q;
    logic k_q, p_q, t2_q;
    logic [3:0] pos_q, cnt_q, tts_q;
    logic [7:0] key;
    // Transmit lane mux
    wire [7:0] dd = acc ? dll_tx_data[8*i +: 8] : pmld_pkg::D_ZERO;
    wire dk = acc & dll_tx_k[i];
    wire [7:0] fv = (os_cnt_q == pmld_pkg::POS_LINK) ? pmld_pkg::LINK_NUM : 8'(i);
    wire [7:0] sd = dk ? dd : dd ^ tx_key;
    assign tx_word_w[8*i +: 8] = lane_disable[i] ? pmld_pkg::K_PAD
      : os_run_q ? (lane_fld ? fv : os_d) : sd;
    assign tx_kw_w[i] = lane_disable[i] | (os_run_q ? (os_k & ~lane_fld) : dk);
    // Sent training sets on this lane
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) tts_q <= 4'h0;
      else if (lt_d != lt_q) tts_q <= 4'h0;
      else if (os_run_q & os_last & ~os_is_skp & ~lane_disable[i] & (tts_q != 4'hf))
        tts_q <= tts_q + 4'h1;
    end
    // Receive decode
    wire com = pmld_pkg::pmld_kmatch(k_q, d_q, pmld_pkg::K_COM);
    wire skp = pmld_pkg::pmld_kmatch(k_q, d_q, pmld_pkg::K_SKP);
    wire fts = pmld_pkg::pmld_kmatch(k_q, d_q, pmld_pkg::K_FTS);
    wire sub = pmld_pkg::pmld_kmatch(k_q, d_q, pmld_pkg::K_PAD)
      | pmld_pkg::pmld_kmatch(k_q, d_q, pmld_pkg::K_IDL);
    wire id = (pos_q == pmld_pkg::POS_ID) & ~k_q;
    wire ts1 = id & (d_q == pmld_pkg::D_TS1);
    wire ts2 = id & (d_q == pmld_pkg::D_TS2);
    pmld_scram u_rx_scram (
      .clk_sys(clk_sys),
      .rst(rst),
      .seed(com),
      .adv(~skp),
      .key(key)
    );
    wire [7:0] dsc = (~k_q & dsk_en) ? d_q ^ key : d_q;
    wire [pmld_pkg::SYM_W-1:0] sym = sub ? {p_q, 1'b0, pmld_pkg::D_ZERO}
      : {p_q, k_q, dsc};
    assign com_w[i] = com;
    assign push_w[i] = sync_q[i] & ~(com | skp | fts) & (dsk_q != pmld_pkg::DSK_OFF);
    // Input capture and set counting
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        d_q <= 8'h00;
        k_q <= 1'b0;
        p_q <= 1'b0;
        pos_q <= 4'h0;
      end else begin
        d_q <= pipe_rx_data[8*i +: 8];
        k_q <= pipe_rx_k[i];
        p_q <= pipe_rx_disp[i];
        pos_q <= com ? 4'h1 : ((pos_q != 4'h0) & (pos_q != pmld_pkg::TS_LAST)) ? pos_q + 4'h1 : 4'h0;
      end
    end
    // Consecutive TS count, restarts when the type changes
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        cnt_q <= 4'h0;
        t2_q <= 1'b0;
      end else if (ts1 | ts2) begin
        t2_q <= ts2;
        cnt_q <= ((t2_q != ts2) | (cnt_q == 4'h0)) ? 4'h1 : (cnt_q == 4'hf) ? cnt_q : cnt_q + 4'h1;
      end
    end
    assign rx_ok_w[i] = lane_disable[i] | ((cnt_q >= pmld_pkg::TS_MIN) & (t2_q == in_cfg));
    assign tx_ok_w[i] = lane_disable[i] | (tts_q >= pmld_pkg::TS_MIN);
    assign rx_ts_cnt[4*i +: 4] = cnt_q;
    assign rx_ts2_flag[i] = t2_q;
    assign tx_ts_cnt[4*i +: 4] = tts_q;
    // Deskew buffer for this lane
    pmld_fifo #(.W(pmld_pkg::SYM_W), .D(pmld_pkg::FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .flush(dsk_flush),
      .in_valid(push_w[i]),
      .in_ready(fill_rdy_w[i]),
      .in_data(sym),
      .out_valid(fo_valid_w[i]),
      .out_ready(rd_w),
      .out_data(fo_data_w[i])
    );
    assign rd_word_w[8*i +: 8] = fo_data_w[i][7:0];
  end

  // ==========================================================
  // Training state machine
  always_comb begin
    lt_d = lt_q;
    unique case (lt_q)
      pmld_pkg::LT_QUIET: if (tmr_done) lt_d = pmld_pkg::LT_DETECT;
      pmld_pkg::LT_DETECT: begin
        if (pipe_phy_status) begin
          lt_d = (pipe_rx_status == pmld_pkg::RXDET_YES) ? pmld_pkg::LT_POLL : pmld_pkg::LT_QUIET;
        end
      end
      pmld_pkg::LT_POLL: if (&rx_ok_w & &tx_ok_w) lt_d = pmld_pkg::LT_CFG;
      pmld_pkg::LT_CFG: if (&rx_ok_w & &tx_ok_w) lt_d = pmld_pkg::LT_L0;
      pmld_pkg::LT_L0: lt_d = pmld_pkg::LT_L0;
      default: lt_d = pmld_pkg::LT_QUIET;
    endcase
  end

  // Deskew state machine; loss of enable or overflow wins
  always_comb begin
    dsk_d = dsk_q;
    unique case (dsk_q)
      pmld_pkg::DSK_OFF: if (dsk_en) dsk_d = pmld_pkg::DSK_HUNT;
      pmld_pkg::DSK_HUNT: if (|com_w) dsk_d = all_sync ? pmld_pkg::DSK_LOCK : pmld_pkg::DSK_WAIT;
      pmld_pkg::DSK_WAIT: begin
        if (all_sync) dsk_d = pmld_pkg::DSK_LOCK;
        else if (timeout) dsk_d = pmld_pkg::DSK_HUNT;
      end
      pmld_pkg::DSK_LOCK: dsk_d = pmld_pkg::DSK_LOCK;
    endcase
    if (~dsk_en) dsk_d = pmld_pkg::DSK_OFF;
    else if (ovf) dsk_d = pmld_pkg::DSK_HUNT;
  end

  // ==========================================================
  // State and timers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lt_q <= pmld_pkg::LT_QUIET;
      tmr_q <= 11'h000;
      skp_tmr_q <= 11'h000;
      skp_pend_q <= 1'b0;
    end else begin
      lt_q <= lt_d;
      tmr_q <= (lt_d != lt_q) ? 11'h000 : tmr_q + 11'h001;
      skp_tmr_q <= (~training & ~dsk_en) | skp_hit ? 11'h000 : skp_tmr_q + 11'h001;
      skp_pend_q <= skp_pend_d & (training | dsk_en);
    end
  end

  // Ordered set sequencing
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      os_run_q <= 1'b0;
      os_cnt_q <= 4'h0;
      os_kind_q <= pmld_pkg::OS_TS1;
      rdy_q <= 1'b0;
    end else begin
      os_run_q <= os_run_d;
      os_cnt_q <= os_next ? 4'h0 : os_run_q ? os_cnt_q + 4'h1 : os_cnt_q;
      if (os_next) os_kind_q <= os_kind_d;
      rdy_q <= rdy_d;
    end
  end

  // Deskew control
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dsk_q <= pmld_pkg::DSK_OFF;
      dsk_cnt_q <= 3'h0;
      sync_q <= 8'h00;
    end else begin
      dsk_q <= dsk_d;
      dsk_cnt_q <= (dsk_q == pmld_pkg::DSK_WAIT) ? dsk_cnt_q + 3'h1 : 3'h0;
      sync_q <= dsk_flush ? 8'h00 : sync_d;
    end
  end

  // ==========================================================
  // Registered outputs; the word holds until the link layer takes it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txd_q <= 64'h0;
      txk_q <= 8'h00;
      det_q <= 1'b0;
      eidle_q <= 1'b1;
      up_q <= 1'b0;
      lock_q <= 1'b0;
      ovf_q <= 1'b0;
      rxw_q <= 64'h0;
      rxv_q <= 1'b0;
    end else begin
      txd_q <= tx_word_w;
      txk_q <= tx_kw_w;
      det_q <= lt_d == pmld_pkg::LT_DETECT;
      eidle_q <= (lt_d == pmld_pkg::LT_QUIET) | (lt_d == pmld_pkg::LT_DETECT);
      up_q <= lt_d == pmld_pkg::LT_L0;
      lock_q <= dsk_d == pmld_pkg::DSK_LOCK;
      ovf_q <= ovf;
      if (rd_w) rxw_q <= rd_word_w;
      if (rd_w) rxv_q <= 1'b1;
      else if (dll_rx_ready) rxv_q <= 1'b0;
    end
  end

  assign pipe_tx_data = txd_q;
  assign pipe_tx_k = txk_q;
  assign pipe_tx_detect_rx = det_q;
  assign pipe_tx_elec_idle = eidle_q;
  assign dll_tx_ready = rdy_q;
  assign dll_rx_data = rxw_q;
  assign dll_rx_valid = rxv_q;
  assign link_up = up_q;
  assign ltssm_state = lt_q;
  assign deskew_locked = lock_q;
  assign deskew_overflow = ovf_q;
endmodule : pmld_top

// [testbench/pmld_top_assertions.sv]
// Checker for pmld_top: training, transmit and deskew relations at the ports.
// Sees only top-level ports; bound into every pmld_top below.
`timescale 1ns/100ps
module pmld_top_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pipe_phy_status,
  input wire logic [2:0] pipe_rx_status,
  input wire logic [63:0] pipe_tx_data,
  input wire logic [7:0] pipe_tx_k,
  input wire logic pipe_tx_detect_rx,
  input wire logic pipe_tx_elec_idle,
  input wire logic [63:0] dll_tx_data,
  input wire logic [7:0] dll_tx_k,
  input wire logic dll_tx_valid,
  input wire logic dll_tx_pkt,
  input wire logic dll_tx_ready,
  input wire logic [63:0] dll_rx_data,
  input wire logic dll_rx_valid,
  input wire logic dll_rx_ready,
  input wire logic [7:0] lane_disable,
  input wire logic link_up,
  input wire logic [2:0] ltssm_state,
  input wire logic deskew_locked,
  input wire logic deskew_overflow
);
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ====
  // Ordered set steps; past state guards the state-change cycle
  sequence s_ts1_com;
    ltssm_state == 3'h2 && $past(ltssm_state) == 3'h2 && pipe_tx_k[0] && pipe_tx_data[7:0] == pmld_pkg::K_COM;
  endsequence
  sequence s_pad_fields;
    (pipe_tx_k[6:0] == 7'h7f && pipe_tx_data[55:0] == {7{pmld_pkg::K_PAD}}) [*2];
  endsequence
  sequence s_ts2_com;
    ltssm_state == 3'h3 && $past(ltssm_state) == 3'h3 && pipe_tx_k[0] && pipe_tx_data[7:0] == pmld_pkg::K_COM;
  endsequence
  sequence s_lane_fields;
    pipe_tx_data[15:8] == pmld_pkg::LINK_NUM ##1
    !pipe_tx_k[2] && pipe_tx_data[23:16] == 8'h02 && pipe_tx_data[15:8] == 8'h01;
  endsequence
  // ====
  // Properties
  a_detect_done: assert property (pipe_tx_detect_rx && pipe_phy_status && pipe_rx_status == 3'h3 |=>
    ltssm_state == 3'h2 && !pipe_tx_detect_rx && !pipe_tx_elec_idle) else $error("detect result not taken");
  a_detect_hold: assert property (pipe_tx_detect_rx && !pipe_phy_status |=> pipe_tx_detect_rx)
    else $error("detect request dropped early");
  a_idle_early: assert property (ltssm_state inside {3'h0, 3'h1} |-> pipe_tx_elec_idle)
    else $error("transmitter active before training");
  a_link_status: assert property (link_up == (ltssm_state == 3'h4))
    else $error("link status disagrees with state");
  a_ts1_pad: assert property (s_ts1_com |=> s_pad_fields)
    else $error("training set fields not padded");
  a_lane_number: assert property (s_ts2_com |=> s_lane_fields)
    else $error("lane number field wrong");
  a_lane_off: assert property (ltssm_state inside {3'h2, 3'h3} && $past(ltssm_state) inside {3'h2, 3'h3}
    && lane_disable[7] |-> pipe_tx_k[7] && pipe_tx_data[63:56] == pmld_pkg::K_PAD)
    else $error("disabled lane not padded");
  a_tx_pass: assert property (dll_tx_valid && dll_tx_ready && dll_tx_k == 8'hff |=>
    pipe_tx_k == 8'hff && pipe_tx_data == $past(dll_tx_data)) else $error("link word not sent");
  a_ready_l0: assert property (dll_tx_ready |-> link_up)
    else $error("transmit ready outside link up");
  a_skp_in_pkt: assert property (dll_tx_ready && dll_tx_pkt |=> dll_tx_ready)
    else $error("ready dropped inside packet");
  a_rx_lock: assert property ($rose(dll_rx_valid) |-> $past(deskew_locked))
    else $error("word read while unaligned");
  a_rx_hold: assert property (dll_rx_valid && !dll_rx_ready |=> dll_rx_valid && $stable(dll_rx_data))
    else $error("receive word not held");
  a_ovf_flush: assert property (deskew_overflow |-> ##[0:2] !deskew_locked)
    else $error("overflow did not resync");
endmodule : pmld_top_checker

bind pmld_top pmld_top_checker u_chk (.clk_sys, .rst, .pipe_phy_status, .pipe_rx_status, .pipe_tx_data,
  .pipe_tx_k, .pipe_tx_detect_rx, .pipe_tx_elec_idle, .dll_tx_data, .dll_tx_k, .dll_tx_valid, .dll_tx_pkt,
  .dll_tx_ready, .dll_rx_data, .dll_rx_valid, .dll_rx_ready, .lane_disable, .link_up, .ltssm_state,
  .deskew_locked, .deskew_overflow);

// [testbench/pmld_phy_model.sv]
// PHY-side partner: answers receiver detect and feeds the receive lanes.
// Echoes our own sets in training; the bench can take over the lanes.
`timescale 1ns/100ps
module pmld_phy_model #(
  parameter int DET_DLY = 5
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [63:0] pipe_tx_data,
  input wire logic [7:0] pipe_tx_k,
  input wire logic pipe_tx_detect_rx,
  input wire logic link_up,
  input wire logic inj,
  input wire logic [63:0] inj_data,
  input wire logic [7:0] inj_k,
  output logic [63:0] pipe_rx_data,
  output logic [7:0] pipe_rx_k,
  output logic [7:0] pipe_rx_disp,
  output logic pipe_phy_status,
  output logic [2:0] pipe_rx_status
);
  logic [3:0] det_q;
  // ====
  // Detect answer: one status pulse after a settle time
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      det_q <= 4'h0;
      pipe_phy_status <= 1'b0;
      pipe_rx_status <= 3'h0;
    end else if (pipe_tx_detect_rx && !pipe_phy_status && det_q == 4'(DET_DLY)) begin
      det_q <= 4'h0;
      pipe_phy_status <= 1'b1;
      pipe_rx_status <= 3'h3;
    end else begin
      det_q <= (pipe_tx_detect_rx && !pipe_phy_status) ? det_q + 4'h1 : 4'h0;
      pipe_phy_status <= 1'b0;
      pipe_rx_status <= 3'h0; // No result outside the pulse
    end
  end
  // ====
  // Receive lanes: skips in L0 so deskew sees no stray sync symbol
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pipe_rx_data <= 64'h0;
      pipe_rx_k <= 8'h0;
      pipe_rx_disp <= 8'h0;
    end else begin
      pipe_rx_data <= inj ? inj_data : link_up ? {8{pmld_pkg::K_SKP}} : pipe_tx_data;
      pipe_rx_k <= inj ? inj_k : link_up ? 8'hff : pipe_tx_k;
      pipe_rx_disp <= ~pipe_rx_disp; // Disparity only rides along
    end
  end
endmodule : pmld_phy_model

// [testbench/test_pcie_phy_mac_lane_deskew.sv]
// Self-checking bench for pmld_top with the PHY partner model.
// Assumes the checker is bound in; one 100 MHz clock.
`timescale 1ns/100ps
module test_pcie_phy_mac_lane_deskew;
  typedef struct packed {logic [63:0] d; logic [7:0] k; logic [63:0] ed; logic [7:0] ek;} pmld_txrow_t;
  localparam logic [7:0] KC = pmld_pkg::K_COM;
  localparam logic [7:0] KP = pmld_pkg::K_PAD;
  localparam logic [7:0] KI = pmld_pkg::K_IDL;
  localparam logic [7:0] KS = pmld_pkg::K_SKP;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [63:0] pipe_rx_data, pipe_tx_data, dll_rx_data;
  logic [7:0] pipe_rx_k, pipe_rx_disp, pipe_tx_k, rx_ts2_flag;
  logic [2:0] pipe_rx_status, ltssm_state;
  logic pipe_phy_status, pipe_tx_detect_rx, pipe_tx_elec_idle, dll_tx_ready, dll_rx_valid;
  logic link_up, deskew_locked, deskew_overflow;
  logic [31:0] rx_ts_cnt, tx_ts_cnt;
  logic [63:0] dll_tx_data = 64'h0;
  logic [63:0] inj_data = 64'h0;
  logic [7:0] dll_tx_k = 8'h0;
  logic [7:0] inj_k = 8'h0;
  logic [7:0] lane_disable = 8'h80;
  logic dll_tx_valid = 1'b0;
  logic dll_tx_pkt = 1'b0;
  logic dll_rx_ready = 1'b1;
  logic inj = 1'b0;
  int bad_count = 0;
  int checked = 0;
  int words = 0;
  int ovf = 0;
  int cyc = 0;
  int i;
  // Lane 7 stays PAD since it is disabled
  pmld_txrow_t rows [3] = '{
    '{64'hf77c7c7c7c7c7c7c, 8'hff, 64'hf77c7c7c7c7c7c7c, 8'hff},
    '{64'hf71c3cf77c1c3cf7, 8'hff, 64'hf71c3cf77c1c3cf7, 8'hff},
    '{64'hf7f7f7f7f7f7f7f7, 8'hff, 64'hf7f7f7f7f7f7f7f7, 8'hff}};

  pmld_top DUT (.clk_sys, .rst, .pipe_rx_data, .pipe_rx_k, .pipe_rx_disp, .pipe_phy_status, .pipe_rx_status,
    .pipe_tx_data, .pipe_tx_k, .pipe_tx_detect_rx, .pipe_tx_elec_idle, .dll_tx_data, .dll_tx_k, .dll_tx_valid,
    .dll_tx_pkt, .dll_tx_ready, .dll_rx_data, .dll_rx_valid, .dll_rx_ready, .lane_disable, .link_up,
    .ltssm_state, .deskew_locked, .deskew_overflow, .rx_ts_cnt, .rx_ts2_flag, .tx_ts_cnt);
  pmld_phy_model u_phy (.clk_sys, .rst, .pipe_tx_data, .pipe_tx_k, .pipe_tx_detect_rx, .link_up, .inj,
    .inj_data, .inj_k, .pipe_rx_data, .pipe_rx_k, .pipe_rx_disp, .pipe_phy_status, .pipe_rx_status);

  // ====
  // Clock, hang limit and receive word monitor
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (dll_rx_valid === 1'b1 && dll_rx_ready === 1'b1) begin
      words++;
      cmp(dll_rx_data, 64'h0, "rx word not zero");
    end
    if (deskew_overflow === 1'b1) ovf++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : cmp

  // Bench takes the receive lanes one symbol per clock
  task automatic put(input logic [63:0] d, input logic [7:0] k);
    @(posedge clk_sys);
    #1;
    inj_data = d;
    inj_k = k;
  endtask : put

  task automatic tally_and_finish();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  // ====
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    cmp(64'({ltssm_state, link_up, dll_tx_ready, dll_rx_valid, pipe_tx_elec_idle}), 64'h1, "reset");
    rst = 1'b0;
    for (i = 0; i < 3000 && link_up !== 1'b1; i++) @(posedge clk_sys);
    #1;
    cmp(64'({tx_ts_cnt, link_up}), 64'h1, "no link");
    cmp(64'({rx_ts_cnt, rx_ts2_flag}), 64'h088888887f, "ts2 flags");
    // Back-to-back words; packet flag keeps skips out
    dll_tx_pkt = 1'b1;
    dll_tx_valid = 1'b1;
    foreach (rows[r]) begin
      dll_tx_data = rows[r].d;
      dll_tx_k = rows[r].k;
      for (i = 0; i < 50 && dll_tx_ready !== 1'b1; i++) begin
        @(posedge clk_sys);
        #1;
      end
      @(posedge clk_sys);
      #1;
      cmp(pipe_tx_data, rows[r].ed, "tx word");
      cmp(64'(pipe_tx_k), 64'(rows[r].ek), "tx k");
    end
    dll_tx_valid = 1'b0;
    dll_tx_pkt = 1'b0;
    for (i = 0; i < 1300 && !(pipe_tx_k[0] === 1'b1 && pipe_tx_data[7:0] === KC); i++) begin
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    #1;
    cmp(64'(pipe_tx_data[55:0]), 64'({7{KS}}), "skip set");
    cmp(64'(dll_tx_ready), 64'h0, "ready during skip");
    // Deskew: no write before sync, then a lane that never syncs
    inj = 1'b1;
    repeat (10) put({8{KP}}, 8'hff);
    cmp(64'(words), 64'h0, "data before sync");
    put({KP, {7{KC}}}, 8'hff);
    repeat (14) put({8{KP}}, 8'hff);
    cmp(64'({deskew_locked, 32'(words)}), 64'h0, "unsynced lane");
    // Skewed sync; FTS dropped, PAD and IDL become zero data
    put({{4{KP}}, {4{KC}}}, 8'hff);
    put({8{KP}}, 8'hff);
    put({{4{KC}}, {4{KI}}}, 8'hff);
    put({8{pmld_pkg::K_FTS}}, 8'hff);
    put({8{KI}}, 8'hff);
    put({8{KP}}, 8'hff);
    repeat (12) put({8{KS}}, 8'hff);
    cmp(64'(words), 64'h2, "deskewed words");
    cmp(64'(deskew_locked), 64'h1, "no lock");
    // Stall the link layer until the lane buffers overflow
    dll_rx_ready = 1'b0;
    repeat (5) put({8{KI}}, 8'hff);
    cmp(64'(ovf), 64'h0, "early overflow");
    repeat (9) put({8{KI}}, 8'hff);
    repeat (4) put({8{KS}}, 8'hff);
    cmp(64'(ovf), 64'h1, "overflow count");
    cmp(64'(deskew_locked), 64'h0, "lock after overflow");
    dll_rx_ready = 1'b1;
    repeat (3) put({8{KS}}, 8'hff);
    cmp(64'(dll_rx_valid), 64'h0, "not drained");
    tally_and_finish();
  end
endmodule : test_pcie_phy_mac_lane_deskew
